// ===== tdsy_sync.sv
// Time-of-day synchronizer: master counter domain to slave counter domain.
// Assumes four clocks (master, slave, sampling, APB) and a reset for each.
//
// Local design decisions: the APB slave port and the address map.
`include "tdsy_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tdsy_sync
   import tdsy_pkg::*;
#(
   parameter int tod_mode = 1,
   parameter int sync_mode = 1,
   parameter logic [3:0] period_whole_ns = `TDSY_WHOLE_156,
   parameter logic [15:0] period_fraction_ns = `TDSY_FRAC_156,
   localparam int TW = (tod_mode == 1) ? 96 : 64
) (
   input wire logic clk_master,
   input wire logic master_rst_n,
   input wire logic [TW-1:0] tod_master_data,
   input wire logic clk_slave,
   input wire logic slave_rst_n,
   input wire logic start_tod_sync,
   output logic tod_slave_valid,
   output logic [TW-1:0] tod_slave_data,
   input wire logic clk_sampling,
   input wire logic sampling_rst_n,
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   localparam int PW = `TDSY_PW;
   localparam int AW = `TDSY_AW;
   localparam int AC = `TDSY_ACC_W;
   localparam int PRW = AC + 20;
   localparam int LW = PRW - `TDSY_WIN_LOG;
   // Mode decode picks fixed periods for mixed rates, parameters otherwise.
   localparam tdsy_period_t P125 = {`TDSY_WHOLE_125, `TDSY_FRAC_125};
   localparam tdsy_period_t P156 = {`TDSY_WHOLE_156, `TDSY_FRAC_156};
   localparam tdsy_period_t PPAR = {period_whole_ns, period_fraction_ns};
   localparam bit EQ = (sync_mode == int'(TDSY_EQUAL));
   localparam bit M125 = (sync_mode == int'(TDSY_M125_S156));
   localparam tdsy_period_t MPER = EQ ? PPAR : (M125 ? P125 : P156);
   localparam tdsy_period_t SPER = EQ ? PPAR : (M125 ? P156 : P125);
   // An entry waits on the slower side, so its age is fill times that period.
   localparam tdsy_period_t LPER = (MPER > SPER) ? MPER : SPER;

   function automatic logic [PW-1:0] g2b(input logic [PW-1:0] g);
      logic [PW-1:0] b;
      b[PW-1] = g[PW-1];
      for (int i = PW - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction : g2b

   function automatic logic [PW-1:0] b2g(input logic [PW-1:0] b);
      return b ^ (b >> 1);
   endfunction : b2g

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      return a == off;
   endfunction : hit

   // Master domain: write port of the crossing FIFO.
   tdsy_tod_t mem [`TDSY_DEPTH];
   logic [PW-1:0] wbin;
   logic [PW-1:0] wgray;
   logic [PW-1:0] rg_m1;
   logic [PW-1:0] rg_m2;
   // The read pointer lives in the slave domain but the write side samples it first.
   logic [PW-1:0] rgray;
   wire tdsy_tod_t master_word = tdsy_tod_t'(96'(tod_master_data));
   wire logic full = (wgray == {~rg_m2[PW-1:PW-2], rg_m2[PW-3:0]});
   wire logic wr = !full;
   wire logic [PW-1:0] next_wbin = wbin + PW'(wr);

   always_ff @(posedge clk_master or negedge master_rst_n) begin
      if (!master_rst_n) begin
         wbin <= '0;
         wgray <= '0;
         rg_m1 <= '0;
         rg_m2 <= '0;
      end else begin
         rg_m1 <= rgray;
         rg_m2 <= rg_m1;
         wbin <= next_wbin;
         wgray <= b2g(next_wbin);
      end
   end

   // The array has no reset so it maps onto dual-clock RAM.
   always_ff @(posedge clk_master) begin
      if (wr) begin
         mem[wbin[AW-1:0]] <= master_word;
      end
   end

   // Slave domain: read port, drained every cycle to keep the fill steady.
   logic [PW-1:0] rbin;
   logic [PW-1:0] wg_r1;
   logic [PW-1:0] wg_r2;
   tdsy_tod_t head_q;
   wire logic empty = (rgray == wg_r2);
   wire logic rd = !empty;
   wire logic [PW-1:0] next_rbin = rbin + PW'(rd);

   always_ff @(posedge clk_slave or negedge slave_rst_n) begin
      if (!slave_rst_n) begin
         rbin <= '0;
         rgray <= '0;
         wg_r1 <= '0;
         wg_r2 <= '0;
         head_q <= '0;
      end else begin
         wg_r1 <= wgray;
         wg_r2 <= wg_r1;
         rbin <= next_rbin;
         rgray <= b2g(next_rbin);
         if (rd) begin
            head_q <= mem[rbin[AW-1:0]];
         end
      end
   end

   // Sampling domain: averages the fill level over one 64-sample window.
   // A window average trades response time for a steadier latency estimate.
   logic [PW-1:0] wg_s1;
   logic [PW-1:0] wg_s2;
   logic [PW-1:0] rg_s1;
   logic [PW-1:0] rg_s2;
   logic [`TDSY_WIN_LOG-1:0] win_cnt;
   logic [AC-1:0] acc;
   logic [AC-1:0] meas;
   logic req_tgl;
   wire logic [PW-1:0] fill = g2b(wg_s2) - g2b(rg_s2);
   wire logic [AC-1:0] next_acc = acc + AC'(fill);
   wire logic win_end = (win_cnt == `TDSY_WIN_LAST);

   always_ff @(posedge clk_sampling or negedge sampling_rst_n) begin
      if (!sampling_rst_n) begin
         wg_s1 <= '0;
         wg_s2 <= '0;
         rg_s1 <= '0;
         rg_s2 <= '0;
         win_cnt <= '0;
         acc <= '0;
         meas <= '0;
         req_tgl <= 1'b0;
      end else begin
         wg_s1 <= wgray;
         wg_s2 <= wg_s1;
         rg_s1 <= rgray;
         rg_s2 <= rg_s1;
         win_cnt <= win_cnt + 1'b1;
         acc <= win_end ? '0 : next_acc;
         if (win_end) begin
            meas <= next_acc;
            req_tgl <= ~req_tgl;
         end
      end
   end

   // Slave domain: takes each measurement while run is high, compensates and presents it.
   // The measurement is held for a whole window, far longer than the sync delay.
   // Data and strobe leave on the same edge, so the partner loads on the next one.
   logic t1;
   logic t2;
   logic t3;
   logic ctl_s1;
   logic ctl_s2;
   logic synced;
   logic [LW-1:0] lat_q;
   tdsy_state_t state;
   logic ctrl_start;
   wire logic run = start_tod_sync | ctl_s2;
   wire logic evt = t2 ^ t3;
   wire logic [PRW-1:0] lat_prod = PRW'(meas) * PRW'(LPER);
   wire logic [LW-1:0] lat = lat_prod[PRW-1:`TDSY_WIN_LOG];
   wire logic [63:0] nf = {head_q.ns, head_q.frac} + 64'(lat_q) + 64'(SPER);
   wire logic roll = (tod_mode == 1) && (nf[63:16] >= `TDSY_NS_PER_S);
   wire logic [47:0] ns_fix = roll ? nf[63:16] - `TDSY_NS_PER_S : nf[63:16];
   wire logic [31:0] sec_fix = head_q.sec + 32'(roll);
   wire tdsy_tod_t comp = '{sec: sec_fix, ns: ns_fix, frac: nf[15:0]};

   always_ff @(posedge clk_slave or negedge slave_rst_n) begin
      if (!slave_rst_n) begin
         t1 <= 1'b0;
         t2 <= 1'b0;
         t3 <= 1'b0;
         ctl_s1 <= 1'b0;
         ctl_s2 <= 1'b0;
         synced <= 1'b0;
         lat_q <= '0;
         state <= TDSY_S_WAIT;
         tod_slave_valid <= 1'b0;
         tod_slave_data <= '0;
      end else begin
         t1 <= req_tgl;
         t2 <= t1;
         t3 <= t2;
         ctl_s1 <= ctrl_start;
         ctl_s2 <= ctl_s1;
         tod_slave_valid <= (state == TDSY_S_CALC);
         case (state)
            TDSY_S_WAIT: begin
               if (evt && run) begin
                  lat_q <= lat;
                  state <= TDSY_S_CALC;
               end
            end
            TDSY_S_CALC: begin
               tod_slave_data <= comp[TW-1:0];
               synced <= 1'b1;
               state <= TDSY_S_WAIT;
            end
            default: begin
               state <= TDSY_S_WAIT;
            end
         endcase
      end
   end

   // APB slave: zero wait states, error on an unmapped address.
   // Status bits cross through two flops each, so a read lags by a few cycles.
   logic sy_p1;
   logic sy_p2;
   logic rn_p1;
   logic rn_p2;
   wire logic setup = psel && !penable;
   wire logic is_ctrl = hit(paddr, `TDSY_OFF_CTRL);
   wire logic is_stat = hit(paddr, `TDSY_OFF_STAT);
   wire logic ctrl_wr = psel && penable && pwrite && is_ctrl;
   wire logic [31:0] stat_word = {30'h0, rn_p2, sy_p2};
   wire logic [31:0] rd_mux = is_ctrl ? {31'h0, ctrl_start} : (is_stat ? stat_word : '0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_start <= 1'b0;
         sy_p1 <= 1'b0;
         sy_p2 <= 1'b0;
         rn_p1 <= 1'b0;
         rn_p2 <= 1'b0;
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         sy_p1 <= synced;
         sy_p2 <= sy_p1;
         rn_p1 <= run;
         rn_p2 <= rn_p1;
         pready <= 1'b1;
         if (setup) begin
            prdata <= pwrite ? '0 : rd_mux;
            pslverr <= !(is_ctrl || is_stat);
         end
         if (ctrl_wr) begin
            ctrl_start <= pwdata[`TDSY_CTRL_START];
         end
      end
   end

   // Checks sit beside the logic so that a broken path fails where it is built.
   wire logic [63:0] out_low = tod_slave_data[63:0];

   a_valid_pulse:
   assert property (@(posedge clk_slave) disable iff (!slave_rst_n)
      tod_slave_valid |=> !tod_slave_valid)
      else $error("Valid strobe lasted more than one cycle.");

   a_valid_cause:
   assert property (@(posedge clk_slave) disable iff (!slave_rst_n)
      tod_slave_valid |-> $past(evt, 2) && $past(run, 2))
      else $error("Valid strobe without a measurement while running.");

   a_window_64:
   assert property (@(posedge clk_sampling) disable iff (!sampling_rst_n)
      $changed(req_tgl) |-> ##64 $changed(req_tgl))
      else $error("Measurement window is not 64 sampling cycles.");

   a_fill_bound:
   assert property (@(posedge clk_sampling) disable iff (!sampling_rst_n)
      fill <= `TDSY_DEPTH)
      else $error("Sampled fill level exceeds FIFO depth.");

   a_wptr_step:
   assert property (@(posedge clk_master) disable iff (!master_rst_n)
      (wbin == $past(wbin)) || (wbin == $past(wbin) + 1'b1))
      else $error("Write pointer jumped.");

   a_rptr_hold:
   assert property (@(posedge clk_slave) disable iff (!slave_rst_n)
      $past(empty) |-> rbin == $past(rbin))
      else $error("Read pointer moved on an empty FIFO.");

   a_comp_exact:
   assert property (@(posedge clk_slave) disable iff (!slave_rst_n)
      tod_slave_valid && !$past(roll) |->
      out_low - $past({head_q.ns, head_q.frac}) == 64'($past(lat_q)) + 64'(SPER))
      else $error("Output differs from latency-corrected master time.");

   a_add_period:
   assert property (@(posedge clk_slave) disable iff (!slave_rst_n)
      tod_slave_valid && !$past(roll) |->
      out_low - $past({head_q.ns, head_q.frac}) >= 64'(SPER))
      else $error("Output lacks the one slave period of load time.");

   a_reset_quiet:
   assert property (@(posedge clk_slave) !slave_rst_n |-> !tod_slave_valid)
      else $error("Valid strobe during slave reset.");

   a_reset_data:
   assert property (@(posedge clk_slave) !slave_rst_n |-> tod_slave_data == '0)
      else $error("Synced time not cleared during slave reset.");

   a_data_hold:
   assert property (@(posedge clk_slave) disable iff (!slave_rst_n)
      !tod_slave_valid |-> $stable(tod_slave_data))
      else $error("Synced time changed without a valid strobe.");

   a_lat_bound:
   assert property (@(posedge clk_slave) disable iff (!slave_rst_n)
      32'(lat_q) <= 32'(LPER) * 32'(`TDSY_DEPTH))
      else $error("Latency estimate exceeds a full FIFO.");

   a_second_carry:
   assert property (@(posedge clk_slave) disable iff (!slave_rst_n)
      tod_slave_valid && (tod_mode == 1) |-> out_low[63:16] < `TDSY_NS_PER_S)
      else $error("Nanoseconds of the synced time reached one second.");

   c_valid: cover property (@(posedge clk_slave) disable iff (!slave_rst_n)
      tod_slave_valid);
   c_second_roll: cover property (@(posedge clk_slave) disable iff (!slave_rst_n)
      state == TDSY_S_CALC && roll);
   c_full: cover property (@(posedge clk_master) disable iff (!master_rst_n) full);
   c_repeat: cover property (@(posedge clk_slave) disable iff (!slave_rst_n)
      tod_slave_valid ##[1:1000] tod_slave_valid);
   c_run_drop: cover property (@(posedge clk_slave) disable iff (!slave_rst_n) $fell(run));
endmodule : tdsy_sync
`default_nettype wire

// ===== tdsy_params.svh
// Constants for the time-of-day domain synchronizer.
// Assumes inclusion by tdsy_sync.sv, the counter model and the bench, not by tdsy_pkg.sv.
`ifndef TDSY_PARAMS_SVH
`define TDSY_PARAMS_SVH
`define TDSY_AW 4
`define TDSY_PW 5
`define TDSY_DEPTH 5'h10
`define TDSY_WIN_LOG 6
`define TDSY_WIN_LAST 6'h3F
`define TDSY_ACC_W 11
`define TDSY_WHOLE_156 4'h6
`define TDSY_FRAC_156 16'h6666
`define TDSY_WHOLE_125 4'h8
`define TDSY_FRAC_125 16'h0000
`define TDSY_NS_PER_S 48'h0000_3B9A_CA00
`define TDSY_OFF_CTRL 12'h000
`define TDSY_OFF_STAT 12'h004
`define TDSY_CTRL_START 0
`define TDSY_STAT_SYNCED 0
`define TDSY_STAT_RUN 1
`endif

// ===== tdsy_pkg.sv
// Types shared by the time-of-day domain synchronizer.
// Assumes the constants header is compiled alongside.
package tdsy_pkg;
   typedef struct packed {
      logic [31:0] sec;
      logic [47:0] ns;
      logic [15:0] frac;
   } tdsy_tod_t;
   typedef logic [19:0] tdsy_period_t;
   typedef enum logic [1:0] {
      TDSY_M125_S156 = 2'b00,
      TDSY_M156_S125 = 2'b01,
      TDSY_EQUAL = 2'b10
   } tdsy_mode_t;
   typedef enum logic [1:0] {
      TDSY_S_WAIT = 2'b00,
      TDSY_S_CALC = 2'b01
   } tdsy_state_t;
endpackage : tdsy_pkg

// ===== tdsy_tod_model.sv
// Behavioural master and slave time counters around the synchronizer.
// Assumes the default rate pairing: master period 6.4 ns, slave 8.0 ns.
`include "tdsy_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tdsy_tod_model
   import tdsy_pkg::*;
(
   input wire logic clk_master,
   input wire logic master_rst_n,
   input wire logic clk_slave,
   input wire logic slave_rst_n,
   input wire tdsy_tod_t tod_init,
   input wire logic load_valid,
   input wire tdsy_tod_t load_data,
   output tdsy_tod_t master_tod,
   output tdsy_tod_t slave_tod
);
   function automatic tdsy_tod_t step(input tdsy_tod_t t, input logic [3:0] w,
                                      input logic [15:0] f);
      logic [16:0] fs;
      tdsy_tod_t n;
      fs = {1'b0, t.frac} + {1'b0, f};
      n = t;
      n.frac = fs[15:0];
      n.ns = t.ns + {44'h000_0000_0000, w} + {47'h0000_0000_0000, fs[16]};
      if (n.ns >= `TDSY_NS_PER_S) begin
         n.ns = n.ns - `TDSY_NS_PER_S;
         n.sec = t.sec + 32'h0000_0001;
      end
      return n;
   endfunction : step
   // The master never pauses for a transfer, so what reaches the slave is old.
   always_ff @(posedge clk_master or negedge master_rst_n) begin
      if (!master_rst_n) begin
         master_tod <= tod_init;
      end else begin
         master_tod <= step(master_tod, `TDSY_WHOLE_156, `TDSY_FRAC_156);
      end
   end
   // Load the edge after the strobe, then count on from the loaded value.
   always_ff @(posedge clk_slave or negedge slave_rst_n) begin
      if (!slave_rst_n) begin
         slave_tod <= '0;
      end else if (load_valid) begin
         slave_tod <= load_data;
      end else begin
         slave_tod <= step(slave_tod, `TDSY_WHOLE_125, `TDSY_FRAC_125);
      end
   end
endmodule : tdsy_tod_model
`default_nettype wire

// ===== tb_time_of_day_domain_sync.sv
// Self-checking bench for the synchronizer at its default parameters.
// Assumes the design and the counter model are compiled before it.
`include "tdsy_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_time_of_day_domain_sync
   import tdsy_pkg::*;
;
   // Tolerance of 64 ns in fraction units; an uncorrected path lags ~128 ns.
   localparam longint TOL = 64'h0000_0000_0040_0000;
   logic pclk = 0, clk_master = 0, clk_slave = 0, clk_sampling = 0;
   logic rst_n = 0, psel = 0, penable = 0, pwrite = 0, start_pin = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready, pslverr, tod_slave_valid;
   logic [95:0] tod_slave_data;
   tdsy_tod_t init = '0;
   tdsy_tod_t m_tod, s_tod;
   logic v64;
   logic [63:0] d64, diff;
   int cnt64 = 0;
   int fail_count = 0, num_checks = 0, n, cnt;
   initial forever #10 pclk = ~pclk;
   initial forever #3.2 clk_master = ~clk_master;
   initial forever #4 clk_slave = ~clk_slave;
   // Sixteen 63rds of the slave rate, as a PLL off the slave clock gives.
   initial forever #15.75 clk_sampling = ~clk_sampling;
   tdsy_sync tdsy_sync_i (.clk_master(clk_master), .master_rst_n(rst_n),
      .tod_master_data(m_tod), .clk_slave(clk_slave), .slave_rst_n(rst_n),
      .start_tod_sync(start_pin), .tod_slave_valid(tod_slave_valid),
      .tod_slave_data(tod_slave_data), .clk_sampling(clk_sampling),
      .sampling_rst_n(rst_n), .pclk(pclk), .presetn(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   tdsy_tod_model tdsy_tod_model_i (.clk_master(clk_master), .master_rst_n(rst_n),
      .clk_slave(clk_slave), .slave_rst_n(rst_n), .tod_init(init),
      .load_valid(tod_slave_valid), .load_data(tod_slave_data),
      .master_tod(m_tod), .slave_tod(s_tod));
   // Equal-rate mode at 8 ns periods scales latency exactly as the default pairing.
   if (1) begin : fmt64
      tdsy_sync #(.tod_mode(0), .sync_mode(2), .period_whole_ns(`TDSY_WHOLE_125),
         .period_fraction_ns(`TDSY_FRAC_125)) tdsy_sync_i (.clk_master(clk_master),
         .master_rst_n(rst_n), .tod_master_data(m_tod[63:0]), .clk_slave(clk_slave),
         .slave_rst_n(rst_n), .start_tod_sync(start_pin), .tod_slave_valid(v64),
         .tod_slave_data(d64), .clk_sampling(clk_sampling), .sampling_rst_n(rst_n),
         .pclk(pclk), .presetn(rst_n), .psel(1'b0), .penable(1'b0), .pwrite(1'b0),
         .paddr(12'h000), .pwdata(32'h0000_0000), .prdata(), .pready(), .pslverr());
   end
   always @(posedge clk_slave) cnt64 <= cnt64 + int'(v64 === 1'b1);
   function automatic longint to_fr(input tdsy_tod_t t);
      return ((longint'(t.sec) * longint'(`TDSY_NS_PER_S) + longint'(t.ns)) <<< 16)
             + longint'(t.frac);
   endfunction : to_fr
   task automatic chk(input string what, input logic [95:0] seen, input logic [95:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : summarize
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] er, input logic ee);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      if (!w) begin
         chk("prdata", {64'h0, prdata}, {64'h0, er});
      end
      chk("pslverr", {95'h0, pslverr}, {95'h0, ee});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_valid(output int k);
      longint d;
      k = 0;
      do begin
         @(posedge clk_slave);
         #1;
         k++;
      end while (tod_slave_valid !== 1'b1 && k < 700);
      chk("valid_seen", {95'h0, tod_slave_valid}, 96'h1);
      @(posedge clk_slave);
      #1;
      chk("valid_width", {95'h0, tod_slave_valid}, 96'h0);
      d = to_fr(s_tod) - to_fr(m_tod);
      chk("tod_error_ok", {95'h0, d < TOL && d > -TOL}, 96'h1);
   endtask : wait_valid
   task automatic endtest(input string name);
      $display("test %s done", name);
   endtask : endtest
   initial begin
      // About 23 us of traffic is expected; thirteen times that means a hang.
      #300us;
      fail_count++;
      summarize();
   end
   initial begin
      void'($urandom(71));
      init.sec = $urandom % 256;
      init.ns = 48'h0000_3B9A_AAC0 + ($urandom % 4000);
      init.frac = 16'($urandom);
      repeat (11) @(posedge pclk);
      chk("reset_valid", {95'h0, tod_slave_valid}, 96'h0);
      chk("reset_data", tod_slave_data, 96'h0);
      chk("reset_pready", {95'h0, pready}, 96'h0);
      @(posedge pclk);
      rst_n <= 1'b1;
      apb(0, 12'h000, 0, 0, 0);
      apb(0, 12'h004, 0, 0, 0);
      apb(0, 12'((($urandom % 1022) + 2) * 4), 0, 0, 1);
      apb(1, 12'((($urandom % 1022) + 2) * 4), $urandom, 0, 1);
      endtest("registers");
      apb(1, 12'h000, 1, 0, 0);
      wait_valid(n);
      for (int r = 0; r < 3; r++) begin
         wait_valid(n);
         chk("spacing", {95'h0, n >= 248 && n <= 254}, 96'h1);
      end
      apb(1, 12'h004, $urandom, 0, 0);
      apb(0, 12'h004, 0, 3, 0);
      endtest("repeat");
      apb(1, 12'h000, 0, 0, 0);
      repeat (300) @(posedge clk_slave);
      cnt = 0;
      repeat (700) begin
         @(posedge clk_slave);
         #1;
         cnt += (tod_slave_valid === 1'b1);
      end
      chk("stopped", 96'(cnt), 96'h0);
      apb(0, 12'h004, 0, 1, 0);
      endtest("stop");
      @(posedge clk_slave);
      start_pin <= 1'b1;
      wait_valid(n);
      wait_valid(n);
      chk("pin_spacing", {95'h0, n >= 248 && n <= 254}, 96'h1);
      chk("fmt64_count", 96'(cnt64), 96'h2);
      diff = d64 - tod_slave_data[63:0];
      chk("fmt64_data", {95'h0, diff == 64'h0 || diff == {`TDSY_NS_PER_S, 16'h0000}}, 96'h1);
      endtest("pin");
      @(posedge pclk);
      rst_n <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("midreset_valid", {95'h0, tod_slave_valid}, 96'h0);
      chk("midreset_pready", {95'h0, pready}, 96'h0);
      chk("midreset_data", tod_slave_data, 96'h0);
      rst_n <= 1'b1;
      wait_valid(n);
      endtest("reset");
      summarize();
   end
endmodule : tb_time_of_day_domain_sync
`default_nettype wire
